// file: hw/mcls_pkg.sv
// Purpose: shared constants for the modem control and line status block
// Assumes: register index = Avalon word address, 8-bit data in the low lane
// Notes: every offset and bit position lives here, and the register reset values except those of the pin and ring flops
package mcls_pkg;
  // register indices (word addresses on the bus)
  localparam logic [3:0] IDX_MODEM_CTRL = 4'h4;
  localparam logic [3:0] IDX_LINE_FLAGS = 4'h5;
  localparam logic [3:0] IDX_IRQ_STATUS = 4'h8;
  localparam logic [3:0] IDX_IRQ_MASK = 4'h9;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // modem_output_control fields
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_AUX1 = 2;
  localparam int MC_OUT2 = 3;
  localparam int MC_LOOP = 4;
  localparam int MC_W = 5;
  localparam logic [4:0] MC_RESET = 5'h00;

  // line_condition_flags fields
  localparam int LF_DATA_READY = 0;
  localparam int LF_ERR_LO = 1;
  localparam int LF_THR_EMPTY = 5;
  localparam int LF_TX_EMPTY = 6;
  localparam int LF_FIFO_ERR = 7;
  localparam logic [3:0] LF_ERR_RESET = 4'h0;
  localparam logic TX_EMPTY_RESET = 1'b1;
  localparam logic FIFO_ERR_RESET = 1'b0;

  // interrupt status / mask fields
  localparam int IRQ_LINE = 0;
  localparam int IRQ_TX_EMPTY = 1;
  localparam int IRQ_RING = 2;
  localparam int IRQ_W = 3;
  localparam logic [2:0] IRQ_RESET = 3'h0;
endpackage

// file: hw/regbus_if.sv
// Purpose: internal register strobe bundle between bus slave and registers
// Assumes: one clock, strobes are single-cycle
// Notes: rd and wr pulse in the cycle the bus answer is given
`timescale 1ns/1ps
interface regbus_if;
  logic rd;
  logic wr;
  logic [3:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport bus (output rd, output wr, output idx, output wdata,
               input rdata);
  modport regs (input rd, input wr, input idx, input wdata,
                output rdata);
endinterface

// file: hw/avmm_slave.sv
// Purpose: Avalon-MM slave front end with one wait state
// Assumes: master holds request until waitrequest is seen low
// Notes: read data are captured in the wait cycle, valid at release
`timescale 1ns/1ps
module avmm_slave (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  regbus_if.bus rb
);
  logic ack_q;
  logic ack_d;
  logic [31:0] readdata_q;
  wire req = read | write;

  // one wait cycle gives time to register read data
  assign ack_d = req & ~ack_q;
  assign waitrequest = req & ~ack_q;
  assign readdata = readdata_q;
  assign rb.idx = address;
  assign rb.wdata = writedata[7:0];
  // only the low lane carries register data
  assign rb.wr = write & ack_q & byteenable[0];
  assign rb.rd = read & ack_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      readdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      if (read & ~ack_q) begin
        readdata_q <= {24'h00_0000, rb.rdata};
      end
    end
  end
endmodule

// file: hw/rx_err_tally.sv
// Purpose: count error-tagged characters resident in the receive FIFO
// Assumes: push/pop come from FIFO logic on the same clock
// Notes: flush empties the tally with the FIFO
`timescale 1ns/1ps
module rx_err_tally #(
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic push_err,
  input wire logic pop_err,
  input wire logic flush,
  output logic any_err
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic any_q;

  // simultaneous push and pop of tagged chars leave the count alone
  assign cnt_d = flush ? '0 :
                 (push_err & ~pop_err) ? cnt_q + CW'(1) :
                 (pop_err & ~push_err & (cnt_q != '0)) ? cnt_q - CW'(1) :
                 cnt_q;
  assign any_err = any_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      any_q <= mcls_pkg::FIFO_ERR_RESET;
    end else begin
      cnt_q <= cnt_d;
      any_q <= (cnt_d != '0);
    end
  end
endmodule

// file: hw/uart_modem_ctrl_line_status.sv
// Purpose: modem output control bits and upper line status flags
// Assumes: receiver/transmitter/FIFO logic on clk, ri_n is a pin
// Notes: registers at word addresses, 8-bit data, one wait state
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
module uart_modem_ctrl_line_status #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  input wire logic fifo_mode,
  input wire logic data_ready,
  input wire logic thr_empty,
  input wire logic tsr_empty,
  input wire logic [3:0] rx_err_set,
  input wire logic rx_push_err,
  input wire logic rx_pop_err,
  input wire logic rx_flush,
  input wire logic ri_n,
  output logic rts_n,
  output logic dtr_n,
  output logic out2_n,
  output logic loopback_en,
  output logic ring_status
);
  regbus_if rb ();

  // register state
  logic [4:0] mc_q;
  logic [4:0] mc_d;
  logic [3:0] lf_err_q;
  logic [3:0] lf_err_d;
  logic [3:0] lf_err_seen_q;
  logic tx_empty_q;
  logic tx_empty_d;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_stat_d;
  logic [2:0] irq_mask_q;
  logic [2:0] irq_mask_d;
  logic [2:0] irq_event;
  logic rts_n_q;
  logic dtr_n_q;
  logic out2_n_q;
  logic ring_q;
  logic ring_d;
  logic ri_s1_q;
  logic ri_s2_q;
  logic fifo_any_err;
  logic fifo_err_view;
  logic [7:0] flags_view;
  logic [7:0] rdata_mux;

  avmm_slave u_slave (
    .clk(clk),
    .rst_n(rst_n),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .byteenable(byteenable),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .rb(rb.bus)
  );

  rx_err_tally #(
    .DEPTH(FIFO_DEPTH)
  ) u_tally (
    .clk(clk),
    .rst_n(rst_n),
    .push_err(rx_push_err),
    .pop_err(rx_pop_err),
    .flush(rx_flush),
    .any_err(fifo_any_err)
  );

  // address decode
  wire hit_mc = (rb.idx == mcls_pkg::IDX_MODEM_CTRL);
  wire hit_lf = (rb.idx == mcls_pkg::IDX_LINE_FLAGS);
  wire hit_is = (rb.idx == mcls_pkg::IDX_IRQ_STATUS);
  wire hit_im = (rb.idx == mcls_pkg::IDX_IRQ_MASK);
  wire wr_mc = rb.wr & hit_mc;
  wire wr_is = rb.wr & hit_is;
  wire wr_im = rb.wr & hit_im;
  wire rd_lf = rb.rd & hit_lf;
  // writes at the line flags index fall through: no register there
  wire wr_lf_ignored = rb.wr & hit_lf;

  // named control bits
  wire loop_bit = mc_q[mcls_pkg::MC_LOOP];
  wire aux1_bit = mc_q[mcls_pkg::MC_AUX1];
  wire rts_bit = mc_q[mcls_pkg::MC_RTS];
  wire dtr_bit = mc_q[mcls_pkg::MC_DTR];
  wire out2_bit = mc_q[mcls_pkg::MC_OUT2];
  wire ri_pin_act = ~ri_s2_q;

  // modem control register: stores all five control bits
  assign mc_d = wr_mc ? rb.wdata[4:0] : mc_q;

  // ring status follows aux1 only in loopback; aux1 never reaches a pin
  assign ring_d = loop_bit ? aux1_bit : ri_pin_act;

  // transmitter empty needs both holding and shift stages empty
  assign tx_empty_d = thr_empty & tsr_empty;

  // error flags: set wins; a read clears only what it has shown, since
  // read data are captured a cycle before the answer edge and an error
  // arriving in that wait cycle would otherwise vanish unseen
  assign lf_err_d = rx_err_set |
                    (lf_err_q & ~(rd_lf ? lf_err_seen_q : 4'h0));

  // global FIFO error is meaningful only in FIFO mode
  assign fifo_err_view = fifo_mode & fifo_any_err;

  assign flags_view = {fifo_err_view, tx_empty_q, thr_empty,
                       lf_err_q, data_ready};

  // interrupt events: any receive error, tx drained, ring edge
  assign irq_event[mcls_pkg::IRQ_LINE] = |rx_err_set;
  assign irq_event[mcls_pkg::IRQ_TX_EMPTY] = tx_empty_d & ~tx_empty_q;
  assign irq_event[mcls_pkg::IRQ_RING] = ring_d ^ ring_q;

  // write-one-to-clear, a new event in the same cycle survives
  assign irq_stat_d = irq_event |
                      (irq_stat_q & ~(wr_is ? rb.wdata[2:0] : 3'h0));
  assign irq_mask_d = wr_im ? rb.wdata[2:0] : irq_mask_q;
  assign irq = |(irq_stat_q & irq_mask_q);

  // read mux; unmapped indices read zero
  assign rdata_mux = hit_mc ? {3'h0, mc_q} :
                     hit_lf ? flags_view :
                     hit_is ? {5'h00, irq_stat_q} :
                     hit_im ? {5'h00, irq_mask_q} : 8'h00;
  assign rb.rdata = rdata_mux;

  // pin outputs come from flops; loopback parks them inactive high
  assign rts_n = rts_n_q;
  assign dtr_n = dtr_n_q;
  assign out2_n = out2_n_q;
  assign loopback_en = loop_bit;
  assign ring_status = ring_q;

  // ring input pin synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ri_s1_q <= 1'b1;
      ri_s2_q <= 1'b1;
    end else begin
      ri_s1_q <= ri_n;
      ri_s2_q <= ri_s1_q;
    end
  end

  // control and status registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mc_q <= mcls_pkg::MC_RESET;
      lf_err_q <= mcls_pkg::LF_ERR_RESET;
      lf_err_seen_q <= mcls_pkg::LF_ERR_RESET;
      tx_empty_q <= mcls_pkg::TX_EMPTY_RESET;
      irq_stat_q <= mcls_pkg::IRQ_RESET;
      irq_mask_q <= mcls_pkg::IRQ_RESET;
      ring_q <= 1'b0;
    end else begin
      mc_q <= mc_d;
      lf_err_q <= lf_err_d;
      lf_err_seen_q <= lf_err_q; // what a read answer carries
      tx_empty_q <= tx_empty_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      ring_q <= ring_d;
    end
  end

  // modem pins: active low, forced high during loopback
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rts_n_q <= 1'b1;
      dtr_n_q <= 1'b1;
      out2_n_q <= 1'b1;
    end else begin
      rts_n_q <= ~(rts_bit & ~loop_bit);
      dtr_n_q <= ~(dtr_bit & ~loop_bit);
      out2_n_q <= ~(out2_bit & ~loop_bit);
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_req_wait;
    (read || write) && waitrequest;
  endsequence

  sequence s_answer;
    !waitrequest ##1 (waitrequest || !(read || write));
  endsequence

  sequence s_mc_write;
    write && !waitrequest && address == mcls_pkg::IDX_MODEM_CTRL
      && byteenable[0];
  endsequence

  a_bus_answer_one: assert property (
    s_req_wait |=> s_answer)
    else $error("bus answer not given after one wait cycle");

  a_aux_no_pin: assert property (
    !loop_bit |=> ring_q == !$past(ri_s2_q))
    else $error("ring status not from pin outside loopback");

  a_ring_from_aux: assert property (
    loop_bit |=> ring_q == $past(aux1_bit))
    else $error("ring status does not follow aux output in loopback");

  a_rts_pin_level: assert property (
    !loop_bit |=> rts_n == !$past(rts_bit))
    else $error("rts pin not inverse of control bit");

  a_dtr_pin_level: assert property (
    !loop_bit |=> dtr_n == !$past(dtr_bit))
    else $error("dtr pin not inverse of control bit");

  a_line_irq_raise: assert property (
    (rx_err_set != 4'h0) && irq_mask_q[mcls_pkg::IRQ_LINE]
      && !wr_im |=> irq && irq_stat_q[mcls_pkg::IRQ_LINE])
    else $error("receive error did not raise line interrupt");

  a_fifo_err_zero: assert property (
    !fifo_mode |-> flags_view[mcls_pkg::LF_FIFO_ERR] == 1'b0)
    else $error("fifo error flag set outside fifo mode");

  a_fifo_err_or: assert property (
    rx_push_err && !rx_pop_err && !rx_flush && fifo_mode
      ##1 fifo_mode |-> flags_view[mcls_pkg::LF_FIFO_ERR])
    else $error("fifo error flag missed a tagged character");

  a_tx_empty_reset: assert property (
    $rose(rst_n) |-> tx_empty_q)
    else $error("transmitter empty not set after reset");

  a_tx_empty_both: assert property (
    ##1 tx_empty_q == ($past(thr_empty) && $past(tsr_empty)))
    else $error("transmitter empty does not match both stages");

  a_loop_pins_high: assert property (
    loop_bit [*2] |-> rts_n && dtr_n && out2_n)
    else $error("modem pins not inactive during loopback");

  a_mc_readback: assert property (
    s_mc_write |=> mc_q == $past(writedata[4:0]))
    else $error("modem control did not store written bits");

  a_lf_write_inert: assert property (
    wr_lf_ignored |=> $stable(lf_err_q) || (|$past(rx_err_set))
      || $past(rd_lf))
    else $error("write to line flags changed them");

  // bus answer and lane gating
  a_read_capture: assert property (
    read && waitrequest |=> !read
      || readdata == {24'h00_0000, $past(rdata_mux)})
    else $error("read data not captured in the wait cycle");

  a_lane_gated: assert property (
    write && !byteenable[0] |=> $stable(mc_q) && $stable(irq_mask_q))
    else $error("write without low lane changed a register");

  a_unmapped_zero: assert property (
    read && !waitrequest && !(hit_mc || hit_lf || hit_is || hit_im)
      |-> readdata == 32'h0000_0000)
    else $error("unmapped index did not read zero");

  // error flags, interrupt status and interrupt mask
  sequence s_err_in_wait;
    read && waitrequest && hit_lf && (rx_err_set != 4'h0);
  endsequence

  a_err_kept: assert property (
    s_err_in_wait ##1 !waitrequest
      |=> (lf_err_q & $past(rx_err_set, 2)) == $past(rx_err_set, 2))
    else $error("receive error lost by a line flags read");

  a_irq_set_wins: assert property (
    irq_event != 3'h0
      |=> (irq_stat_q & $past(irq_event)) == $past(irq_event))
    else $error("interrupt event lost against a clear");

  a_mask_store: assert property (
    write && !waitrequest && byteenable[0]
      && address == mcls_pkg::IDX_IRQ_MASK
      |=> irq_mask_q == $past(writedata[2:0]))
    else $error("interrupt mask did not store written bits");

  a_w1c_clears: assert property (
    write && !waitrequest && byteenable[0] && irq_event == 3'h0
      && address == mcls_pkg::IDX_IRQ_STATUS
      |=> (irq_stat_q & $past(writedata[2:0])) == 3'h0)
    else $error("written ones did not clear interrupt status");

  a_tx_drain_event: assert property (
    thr_empty && tsr_empty && !tx_empty_q
      |=> irq_stat_q[mcls_pkg::IRQ_TX_EMPTY])
    else $error("transmitter drain did not set its status bit");

  // pins and ring path
  a_ring_event: assert property (
    $changed(ring_q) |-> irq_stat_q[mcls_pkg::IRQ_RING])
    else $error("ring change did not set its status bit");

  a_out2_pin_level: assert property (
    !loop_bit |=> out2_n == !$past(out2_bit))
    else $error("out2 pin not inverse of control bit");

  // two flops on the ring pin before anything reads it
  a_ri_sync: assert property (
    ##2 ri_s2_q == $past(ri_n, 2))
    else $error("ring pin not passed through two flops");
endmodule

// file: test/line_partner.sv
// Purpose: stand-in for the modem on the far side of the pins
// Assumes: ring indicator is an active-low line driven by the modem
// Notes: rts_n and dtr_n are watched by the bench, not acted on here
`timescale 1ns/1ps
module line_partner (
  input wire logic clk,
  input wire logic rts_n,
  input wire logic dtr_n,
  input wire logic ring_req,
  output logic ri_n = 1'b1
);
  // ring line moves only after a clock edge, like a sampled modem line
  always @(posedge clk) begin
    ri_n <= ~ring_req;
  end
endmodule

// file: test/tb.sv
// Purpose: self-checking bench for modem control and line flags
// Assumes: one clock, Avalon slave answering after its wait state
// Notes: read results are checked from a queue of expected words
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest, irq, rts_n, dtr_n, out2_n, loopback_en, ring_status;
  logic fifo_mode = 1'b0;
  logic data_ready = 1'b0;
  logic thr_empty = 1'b1;
  logic tsr_empty = 1'b1;
  logic [3:0] rx_err_set = 4'h0;
  logic rx_push_err = 1'b0;
  logic rx_pop_err = 1'b0;
  logic rx_flush = 1'b0;
  logic ring_req = 1'b0;
  logic ri_n;
  logic [31:0] exp_q[$];
  logic [7:0] v;
  int bad_count = 0;
  int cmp_count = 0;

  always #20 clk = ~clk;

  // only lane 0 carries the 8-bit registers; its enable gates writes
  uart_modem_ctrl_line_status #(.FIFO_DEPTH(4))
    uart_modem_ctrl_line_status_inst (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .fifo_mode(fifo_mode), .data_ready(data_ready),
    .thr_empty(thr_empty), .tsr_empty(tsr_empty),
    .rx_err_set(rx_err_set), .rx_push_err(rx_push_err),
    .rx_pop_err(rx_pop_err), .rx_flush(rx_flush), .ri_n(ri_n),
    .rts_n(rts_n), .dtr_n(dtr_n), .out2_n(out2_n),
    .loopback_en(loopback_en), .ring_status(ring_status));

  line_partner line_partner_inst (.clk(clk), .rts_n(rts_n),
    .dtr_n(dtr_n), .ring_req(ring_req), .ri_n(ri_n));

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // request held until waitrequest is sampled low at a rising edge;
  // only the watchdog ends a wait that never finishes
  task automatic bus(logic wr, logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    address <= a;
    writedata <= {24'h0, d};
    read <= ~wr;
    write <= wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a, logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, a, 8'h00);
  endtask

  task automatic idle(int n);
    repeat (n) @(posedge clk);
  endtask

  // read answer taken at the edge where waitrequest is sampled low
  always @(posedge clk) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      if (exp_q.size() == 0) bad_count++;
      else chk("readdata", readdata, exp_q.pop_front());
    end
  end

  // generous bound: the sequence needs well under 2000 cycles
  initial begin
    #(40 * 20000);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h7B57));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(mcls_pkg::IDX_MODEM_CTRL, 8'h00);
    rd(mcls_pkg::IDX_LINE_FLAGS, 8'h60);
    chk("reset pins", {rts_n, dtr_n}, 32'h3);
    // random control bits outside loopback
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom()) & 8'h0F;
      ring_req <= 1'($urandom());
      bus(1'b1, mcls_pkg::IDX_MODEM_CTRL, v);
      rd(mcls_pkg::IDX_MODEM_CTRL, v);
      idle(5);
      chk("rts_n", rts_n, !v[1]);
      chk("dtr_n", dtr_n, !v[0]);
      chk("ring", {out2_n, ring_status}, {!v[3], ring_req});
    end
    // loopback: pins parked high, aux bit feeds ring status
    for (int i = 0; i < 2; i++) begin
      v = i[0] ? 8'h1F : 8'h1B;
      bus(1'b1, mcls_pkg::IDX_MODEM_CTRL, v);
      idle(5);
      chk("loop pins", {loopback_en, rts_n, dtr_n, out2_n}, 32'hF);
      chk("ring loop", ring_status, v[2]);
    end
    bus(1'b1, mcls_pkg::IDX_MODEM_CTRL, 8'h00);
    // a write without the low lane must leave the register alone
    byteenable <= 4'hE;
    bus(1'b1, mcls_pkg::IDX_MODEM_CTRL, 8'h1F);
    byteenable <= 4'hF;
    rd(mcls_pkg::IDX_MODEM_CTRL, 8'h00);
    // every holding/shift combination
    for (int i = 0; i < 4; i++) begin
      thr_empty <= i[0];
      tsr_empty <= i[1];
      data_ready <= 1'($urandom());
      idle(3);
      v = {1'b0, &i[1:0], i[0], 4'h0, data_ready};
      rd(mcls_pkg::IDX_LINE_FLAGS, v);
    end
    data_ready <= 1'b0;
    bus(1'b1, mcls_pkg::IDX_IRQ_MASK, 8'h01);
    // each receive error alone raises the line interrupt
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, mcls_pkg::IDX_IRQ_STATUS, 8'h07);
      idle(2);
      chk("irq idle", irq, 0);
      rx_err_set <= 4'h1 << k;
      @(posedge clk);
      rx_err_set <= 4'h0;
      idle(3);
      chk("irq", irq, 1);
      rd(mcls_pkg::IDX_IRQ_STATUS, 8'h01);
      rd(mcls_pkg::IDX_LINE_FLAGS, 8'h60 | (8'h02 << k));
      rd(mcls_pkg::IDX_LINE_FLAGS, 8'h60);
    end
    bus(1'b1, mcls_pkg::IDX_IRQ_MASK, 8'h00);
    idle(2);
    chk("irq masked", irq, 0);
    // an error arriving in a read's wait cycle survives that read
    fork
      rd(mcls_pkg::IDX_LINE_FLAGS, 8'h60);
      begin
        @(posedge clk);
        rx_err_set <= 4'h1;
        @(posedge clk);
        rx_err_set <= 4'h0;
      end
    join
    rd(mcls_pkg::IDX_LINE_FLAGS, 8'h62);
    rd(mcls_pkg::IDX_LINE_FLAGS, 8'h60);
    // two tagged chars pushed outside fifo mode, flag read outside then inside it
    rx_push_err <= 1'b1;
    idle(2);
    rx_push_err <= 1'b0;
    idle(4);
    rd(mcls_pkg::IDX_LINE_FLAGS, 8'h60);
    fifo_mode <= 1'b1;
    idle(2);
    rd(mcls_pkg::IDX_LINE_FLAGS, 8'hE0);
    for (int i = 0; i < 2; i++) begin
      rx_pop_err <= 1'b1;
      @(posedge clk);
      rx_pop_err <= 1'b0;
      idle(4);
      rd(mcls_pkg::IDX_LINE_FLAGS, i ? 8'h60 : 8'hE0);
    end
    rx_push_err <= 1'b1;
    @(posedge clk);
    rx_push_err <= 1'b0;
    rx_flush <= 1'b1;
    @(posedge clk);
    rx_flush <= 1'b0;
    idle(4);
    rd(mcls_pkg::IDX_LINE_FLAGS, 8'h60);
    // refused writes and an unmapped place
    bus(1'b1, mcls_pkg::IDX_LINE_FLAGS, 8'hFF);
    rd(mcls_pkg::IDX_LINE_FLAGS, 8'h60);
    bus(1'b1, 4'h3, 8'hA5);
    rd(4'h3, 8'h00);
    idle(2);
    tally_and_finish();
  end
endmodule
